// File: see_pkg.sv
// Package for the two-wire EEPROM slave: timing constants, address codes, states.
// Assumes a 100 MHz system clock; nothing else.
package see_pkg;
	localparam int CLK_MHZ = 100;
	// Longest program cycle in milliseconds; the cycle count is an exact product.
	localparam int PROGRAM_CYCLE_TIME_MS = 10;
	localparam int PROGRAM_CYCLES = PROGRAM_CYCLE_TIME_MS * 1000 * CLK_MHZ;
	// Glitch filter span in nanoseconds; a pulse this long or shorter is ignored.
	localparam int GLITCH_FILTER_TIME_NS = 100;
	localparam int GLITCH_CYCLES = (GLITCH_FILTER_TIME_NS * CLK_MHZ + 999) / 1000;
	// Device-type code; the value is arbitrary.
	localparam logic [3:0] DEV_TYPE_CODE = 4'h5;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [10:0] ADDR_ZERO = 11'h000;
	typedef enum logic [2:0] {
		SEE_IDLE = 3'b000,
		SEE_DEVADDR = 3'b001,
		SEE_ACK_OUT = 3'b010,
		SEE_WADDR = 3'b011,
		SEE_WDATA = 3'b100,
		SEE_RDATA = 3'b101,
		SEE_RACK_IN = 3'b110,
		SEE_WAIT_STOP = 3'b111
	} see_state_type;
	// Filtered and edge-decoded bus lines.
	typedef struct packed {
		logic scl;
		logic sda;
		logic scl_rise;
		logic scl_fall;
		logic start;
		logic stop;
	} see_bus_type;
endpackage

// File: see_eeprom.sv
// Two-wire serial EEPROM slave with acknowledge polling and read modes.
// Assumes the bus lines come from another domain and are synchronised here.
`timescale 1ns/1ps

module see_eeprom #(
	parameter int ADDR_W = 11,
	parameter int SEL_BITS = 0,
	parameter int PROG_CYCLES = see_pkg::PROGRAM_CYCLES
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic nrst_i,
	// Two-wire bus
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	// Address-select straps
	input wire logic addr_select_pin0,
	input wire logic addr_select_pin1,
	input wire logic addr_select_pin2,
	// Status
	output logic busy_o
);
	localparam int DEPTH = 1 << ADDR_W;
	localparam int HI_W = 3 - SEL_BITS;

	initial begin
		if (ADDR_W < 8 || ADDR_W > 11 || SEL_BITS + ADDR_W - 8 != 3 || PROG_CYCLES < 1) begin
			$error("see_eeprom: unsupported parameters");
		end
	end

	// Two-flop synchronisers, then a stability filter per line.
	logic [1:0] s1_q, s2_q, s1_d, s2_d;
	logic [1:0] filt_q, filt_d;
	logic [1:0][7:0] gcnt_q, gcnt_d;
	see_pkg::see_bus_type bus;

	always_comb begin
		s1_d = {scl_i, sda_i};
		s2_d = s1_q;
		for (int i = 0; i < 2; i++) begin
			if (s2_q[i] == filt_q[i]) begin
				gcnt_d[i] = 8'h00;
				filt_d[i] = filt_q[i];
			end else if (gcnt_q[i] >= 8'(see_pkg::GLITCH_CYCLES)) begin
				gcnt_d[i] = 8'h00;
				filt_d[i] = s2_q[i];
			end else begin
				gcnt_d[i] = gcnt_q[i] + 8'h01;
				filt_d[i] = filt_q[i];
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			s1_q <= 2'h3;
			s2_q <= 2'h3;
			filt_q <= 2'h3;
			gcnt_q <= '0;
		end else begin
			s1_q <= s1_d;
			s2_q <= s2_d;
			filt_q <= filt_d;
			gcnt_q <= gcnt_d;
		end
	end

	always_comb begin
		bus.scl = filt_q[1];
		bus.sda = filt_q[0];
		bus.scl_rise = filt_d[1] & ~filt_q[1];
		bus.scl_fall = ~filt_d[1] & filt_q[1];
		bus.start = filt_q[1] & filt_d[1] & filt_q[0] & ~filt_d[0];
		bus.stop = filt_q[1] & filt_d[1] & ~filt_q[0] & filt_d[0];
	end

	// Protocol engine.
	logic [7:0] mem [DEPTH];
	see_pkg::see_state_type st_q, st_d;
	logic [7:0] sh_q, sh_d;
	logic [2:0] bit_q, bit_d;
	logic [ADDR_W-1:0] ptr_q, ptr_d;
	logic rd_q, rd_d, ack_q, ack_d, pend_q, pend_d, drv_q, drv_d;
	// Set once the word address of this transfer has been taken.
	logic word_q, word_d;
	logic [ADDR_W-1:0] waddr_q, waddr_d;
	logic [7:0] wdata_q, wdata_d;
	logic [31:0] prog_q, prog_d;
	logic busy_d, match, we;
	logic [2:0] pins;

	assign pins = {addr_select_pin2, addr_select_pin1, addr_select_pin0};

	always_comb begin
		match = (sh_q[7:4] == see_pkg::DEV_TYPE_CODE);
		for (int i = 0; i < 3; i++) begin
			if (i >= HI_W && sh_q[1 + i] != pins[i]) begin
				match = 1'b0;
			end
		end
	end

	always_comb begin
		st_d = st_q;
		sh_d = sh_q;
		bit_d = bit_q;
		ptr_d = ptr_q;
		rd_d = rd_q;
		ack_d = ack_q;
		pend_d = pend_q;
		drv_d = drv_q;
		word_d = word_q;
		waddr_d = waddr_q;
		wdata_d = wdata_q;
		prog_d = prog_q;
		busy_d = busy_o;
		we = 1'b0;
		if (busy_o) begin
			if (prog_q == 32'h0) begin
				busy_d = 1'b0;
				we = 1'b1;
			end else begin
				prog_d = prog_q - 32'h1;
			end
		end
		if (bus.stop) begin
			st_d = see_pkg::SEE_IDLE;
			drv_d = 1'b0;
			if (pend_q && !busy_o) begin
				busy_d = 1'b1;
				prog_d = 32'(PROG_CYCLES - 1);
				pend_d = 1'b0;
			end
		end else if (bus.start) begin
			st_d = see_pkg::SEE_DEVADDR;
			bit_d = 3'h0;
			drv_d = 1'b0;
			pend_d = 1'b0;
			word_d = 1'b0;
			// The clock fall that closes the start is not the end of a byte.
			ack_d = 1'b1;
		end else begin
			unique case (st_q)
				see_pkg::SEE_IDLE, see_pkg::SEE_WAIT_STOP: begin
					drv_d = 1'b0;
				end
				see_pkg::SEE_DEVADDR, see_pkg::SEE_WADDR, see_pkg::SEE_WDATA: begin
					if (bus.scl_rise) begin
						sh_d = {sh_q[6:0], bus.sda};
						bit_d = bit_q + 3'h1;
					end
					if (bus.scl_fall && bit_q == 3'h0 && st_q != see_pkg::SEE_IDLE
						&& ack_q == 1'b0) begin
						ack_d = 1'b1;
						if (st_q == see_pkg::SEE_DEVADDR) begin
							rd_d = sh_q[0];
							if (match && !busy_o) begin
								drv_d = 1'b1;
								st_d = see_pkg::SEE_ACK_OUT;
								if (HI_W > 0) begin
									ptr_d[ADDR_W-1 -: 3] = sh_q[3:1] & 3'((8'h7 >> SEL_BITS));
								end
							end else begin
								st_d = see_pkg::SEE_WAIT_STOP;
							end
						end else if (st_q == see_pkg::SEE_WADDR) begin
							ptr_d[7:0] = sh_q;
							word_d = 1'b1;
							drv_d = 1'b1;
							st_d = see_pkg::SEE_ACK_OUT;
						end else begin
							waddr_d = ptr_q;
							wdata_d = sh_q;
							ptr_d = ptr_q + 1'b1;
							pend_d = 1'b1;
							drv_d = 1'b1;
							st_d = see_pkg::SEE_ACK_OUT;
						end
					end else if (bus.scl_rise) begin
						ack_d = 1'b0;
					end
				end
				see_pkg::SEE_ACK_OUT: begin
					if (bus.scl_fall) begin
						bit_d = 3'h0;
						ack_d = 1'b0;
						if (rd_q) begin
							sh_d = mem[ptr_q];
							ptr_d = ptr_q + 1'b1;
							drv_d = ~mem[ptr_q][7];
							st_d = see_pkg::SEE_RDATA;
						end else begin
							drv_d = 1'b0;
							// A word address may look like a slave address, so track the phase.
							st_d = word_q ? see_pkg::SEE_WDATA : see_pkg::SEE_WADDR;
						end
					end
				end
				see_pkg::SEE_RDATA: begin
					if (bus.scl_fall) begin
						if (bit_q == see_pkg::BIT_LAST) begin
							drv_d = 1'b0;
							st_d = see_pkg::SEE_RACK_IN;
						end else begin
							sh_d = {sh_q[6:0], 1'b0};
							drv_d = ~sh_q[6];
							bit_d = bit_q + 3'h1;
						end
					end
				end
				see_pkg::SEE_RACK_IN: begin
					if (bus.scl_rise) begin
						ack_d = ~bus.sda;
					end
					if (bus.scl_fall) begin
						if (ack_q) begin
							bit_d = 3'h0;
							sh_d = mem[ptr_q];
							ptr_d = ptr_q + 1'b1;
							drv_d = ~mem[ptr_q][7];
							st_d = see_pkg::SEE_RDATA;
						end else begin
							st_d = see_pkg::SEE_WAIT_STOP;
						end
						ack_d = 1'b0;
					end
				end
			endcase
		end
	end

	// The array keeps its content across reset, as the real cells would.
	always_ff @(posedge clock_i) begin
		if (we) begin
			mem[waddr_q] <= wdata_q;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			st_q <= see_pkg::SEE_IDLE;
			sh_q <= 8'h00;
			bit_q <= 3'h0;
			ptr_q <= see_pkg::ADDR_ZERO[ADDR_W-1:0];
			rd_q <= 1'b0;
			ack_q <= 1'b0;
			pend_q <= 1'b0;
			drv_q <= 1'b0;
			word_q <= 1'b0;
			waddr_q <= '0;
			wdata_q <= 8'h00;
			prog_q <= 32'h0;
			busy_o <= 1'b0;
		end else begin
			st_q <= st_d;
			sh_q <= sh_d;
			bit_q <= bit_d;
			ptr_q <= ptr_d;
			rd_q <= rd_d;
			ack_q <= ack_d;
			pend_q <= pend_d;
			drv_q <= drv_d;
			word_q <= word_d;
			waddr_q <= waddr_d;
			wdata_q <= wdata_d;
			prog_q <= prog_d;
			busy_o <= busy_d;
		end
	end

	// Open drain: only ever pull low.
	assign sda_o = 1'b0;
	always_comb sda_oe_o = drv_q;

	a_sda_low_only: assert property (@(posedge clock_i) disable iff (!nrst_i)
		sda_oe_o |-> !sda_o) else $error("data driven high");
	a_busy_from_stop: assert property (@(posedge clock_i) disable iff (!nrst_i)
		(bus.stop && pend_q && !busy_o) |=> busy_o) else $error("no program start");
	a_no_ack_busy: assert property (@(posedge clock_i) disable iff (!nrst_i)
		(busy_o && st_q == see_pkg::SEE_DEVADDR) |=> st_q != see_pkg::SEE_ACK_OUT)
		else $error("acked while busy");
	a_prog_bounded: assert property (@(posedge clock_i) disable iff (!nrst_i)
		busy_o |-> prog_q < 32'(PROG_CYCLES)) else $error("program too long");
	a_ack_when_free: assert property (@(posedge clock_i) disable iff (!nrst_i)
		(st_q == see_pkg::SEE_DEVADDR && bus.scl_fall && bit_q == 3'h0 && !ack_q
		&& match && !busy_o && !bus.start && !bus.stop) |=> sda_oe_o)
		else $error("poll not acked");
	a_ptr_step: assert property (@(posedge clock_i) disable iff (!nrst_i)
		(st_q == see_pkg::SEE_ACK_OUT && rd_q && bus.scl_fall && !bus.start && !bus.stop)
		|=> ptr_q == $past(ptr_q) + 1'b1) else $error("counter not stepped");
	a_release_ack: assert property (@(posedge clock_i) disable iff (!nrst_i)
		st_q == see_pkg::SEE_RACK_IN |-> !sda_oe_o) else $error("ack slot driven");
	a_nack_ends: assert property (@(posedge clock_i) disable iff (!nrst_i)
		(st_q == see_pkg::SEE_RACK_IN && bus.scl_fall && !ack_q && !bus.start && !bus.stop)
		|=> st_q == see_pkg::SEE_WAIT_STOP ##1 !sda_oe_o) else $error("no stop after nack");
	c_poll_busy: cover property (@(posedge clock_i) busy_o && bus.start);
	c_seq_read: cover property (@(posedge clock_i) st_q == see_pkg::SEE_RACK_IN && ack_q);
	c_wrap: cover property (@(posedge clock_i) rd_q && ptr_q == '0 && $past(ptr_q) != '0);
endmodule // see_eeprom

// File: see_mst.sv
// Behavioural two-wire bus master that faces the EEPROM slave.
// Assumes a pull-up on the data line and a 100 MHz reference clock.
`timescale 1ns/1ps
module see_mst (
	// Reference clock and slave drive
	input wire logic clock_i,
	input wire logic sda_oe_i,
	// Resolved bus lines
	output logic scl_o,
	output logic sda_o
);
	localparam int Q = 25;
	logic sda_m = 1'b1;
	// A released line floats to the pull-up level.
	assign sda_o = sda_m & ~sda_oe_i;
	initial scl_o = 1'b1;
	task automatic tick(input int n);
		repeat (n) @(negedge clock_i);
	endtask
	task automatic start();
		sda_m = 1'b1;
		tick(Q);
		scl_o = 1'b1;
		tick(Q);
		sda_m = 1'b0;
		tick(Q);
		scl_o = 1'b0;
		tick(Q);
	endtask
	task automatic stop();
		sda_m = 1'b0;
		tick(Q);
		scl_o = 1'b1;
		tick(Q);
		sda_m = 1'b1;
		tick(2 * Q);
	endtask
	task automatic bitx(input logic b, output logic r);
		sda_m = b;
		tick(Q);
		scl_o = 1'b1;
		tick(Q);
		r = sda_o;
		tick(Q);
		scl_o = 1'b0;
		tick(Q);
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], r);
		end
		bitx(1'b1, r);
		ack = ~r;
	endtask
	// Drive a low on the ninth clock to ask for more, leave it high to end.
	task automatic rbyte(input logic ack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(1'b1, d[i]);
		end
		bitx(~ack, r);
	endtask
endmodule // see_mst

// File: serial_eeprom_read_and_ack_poll_tb.sv
// Self-checking bench for the EEPROM slave: polling, wrap and read modes.
// Assumes the master model above and a shortened program cycle.
`timescale 1ns/1ps
module serial_eeprom_read_and_ack_poll_tb;
	localparam int PROG = 2500;
	logic clock_i = 1'b0;
	logic nrst_i = 1'b0;
	logic scl, sda, sda_o, sda_oe, busy, ack;
	logic strap = 1'b0;
	logic [7:0] d [3];
	logic [7:0] r;
	int n_errors = 0;
	int n_compared = 0;
	int cyc = 0;
	initial forever #5 clock_i = ~clock_i;
	see_eeprom #(.ADDR_W(11), .SEL_BITS(0), .PROG_CYCLES(PROG)) u_dut (
		.clock_i(clock_i), .nrst_i(nrst_i), .scl_i(scl), .sda_i(sda),
		.sda_o(sda_o), .sda_oe_o(sda_oe), .addr_select_pin0(strap),
		.addr_select_pin1(1'b0), .addr_select_pin2(1'b0), .busy_o(busy));
	see_mst u_mst (.clock_i(clock_i), .sda_oe_i(sda_oe), .scl_o(scl), .sda_o(sda));
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim();
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	function automatic logic [7:0] saddr(input logic [10:0] a, input logic rd);
		return {see_pkg::DEV_TYPE_CODE, a[10:8], rd};
	endfunction
	task automatic wr(input logic [10:0] a, input logic [7:0] v);
		int k;
		u_mst.start();
		u_mst.wbyte(saddr(a, 1'b0), ack);
		chk(8'(ack), 8'h01);
		u_mst.wbyte(a[7:0], ack);
		u_mst.wbyte(v, ack);
		chk(8'(ack), 8'h01);
		u_mst.stop();
		chk(8'(busy), 8'h01);
		k = 0;
		ack = 1'b0;
		// Each poll lasts about 1000 cycles, so four cover the shortened cycle.
		while (ack !== 1'b1 && k < 4) begin
			u_mst.start();
			u_mst.wbyte(saddr(a, 1'b0), ack);
			if (ack !== 1'b1)
				chk(8'(busy), 8'h01);
			k++;
		end
		u_mst.stop();
		chk(8'(ack), 8'h01);
		chk(8'(k > 1), 8'h01);
		chk(8'(busy), 8'h00);
	endtask
	always @(posedge clock_i) begin
		cyc++;
		if (cyc > 80000) begin
			n_errors++;
			end_sim();
		end
	end
	initial begin
		void'($urandom(16844));
		repeat (3) @(posedge clock_i);
		@(negedge clock_i);
		nrst_i = 1'b1;
		u_mst.tick(10);
		foreach (d[i])
			d[i] = 8'($urandom);
		strap = 1'($urandom);
		chk(8'(busy), 8'h00);
		u_mst.start();
		u_mst.wbyte({~see_pkg::DEV_TYPE_CODE, 4'h0}, ack);
		chk(8'(ack), 8'h00);
		u_mst.stop();
		wr(11'h7ff, d[0]);
		wr(11'h000, d[1]);
		wr(11'h001, d[2]);
		u_mst.start();
		u_mst.wbyte(saddr(11'h7ff, 1'b0), ack);
		u_mst.wbyte(8'hff, ack);
		u_mst.start();
		u_mst.wbyte(saddr(11'h7ff, 1'b1), ack);
		chk(8'(ack), 8'h01);
		u_mst.rbyte(1'b1, r);
		chk(r, d[0]);
		chk(8'(sda_o), 8'h00);
		u_mst.rbyte(1'b0, r);
		chk(r, d[1]);
		u_mst.stop();
		u_mst.start();
		u_mst.wbyte(saddr(11'h000, 1'b1), ack);
		chk(8'(ack), 8'h01);
		u_mst.rbyte(1'b0, r);
		chk(r, d[2]);
		u_mst.stop();
		end_sim();
	end
endmodule // serial_eeprom_read_and_ack_poll_tb
